// *** shared/adc_if_pkg.sv ***
// Shared constants and types for the converter host interface.
// Assumes a 100 MHz reference clock and a host-driven serial clock.
package adc_if_pkg;

    // Reference clock period
    localparam int CLK_PERIOD_NS = 10;

    // End-of-conversion pulse length, nominal, rounded down to cycles
    localparam int EOC_PULSE_NS = 80;
    localparam int EOC_PULSE_CYC = (EOC_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   EOC_PULSE_NS / CLK_PERIOD_NS;

    // Settling and acquisition delay after a control write, least time
    localparam int ACQ_DELAY_NS = 400;
    localparam int ACQ_DELAY_CYC = (ACQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Conversion duration stand-in, least time
    localparam int CONV_TIME_NS = 1500;
    localparam int CONV_TIME_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Widths
    localparam int DATA_W = 12;
    localparam int CTRL_W = 6;
    localparam int SER_FRAME_BITS = 16;
    localparam int CNT_W = 8;

    // Serial frame lengths as sized constants
    localparam logic [4:0] SER_IN_BITS = 5'h06;
    localparam logic [4:0] SER_OUT_BITS = 5'h10;

    // Control word layout, bit 5 down to bit 0
    typedef struct packed {
        logic [2:0] chan_addr;        // Channel address, bit 2 is most significant
        logic soft_convert_bit;       // Start conversion after the write delay
        logic soft_standby_bit;       // Standby request
        logic coding_sel;             // 1: two's complement, 0: straight binary
    } ctrl_t;

    // Power-on value of the control word
    localparam ctrl_t CTRL_RESET = '{chan_addr: 3'h0, soft_convert_bit: 1'b0,
                                    soft_standby_bit: 1'b0, coding_sel: 1'b0};

    // Pins from the host side of the parallel port and the frame strobes
    typedef struct packed {
        logic mode;                   // 1: parallel, 0: serial
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic convert_start_in;
        logic tx_frame_sync_n;
        logic rx_frame_sync_n;
        logic [DATA_W-1:0] data_pins;
    } pins_t;

    // Idle level of the synchronised pins
    localparam pins_t PINS_IDLE = '{mode: 1'b1, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                   convert_start_in: 1'b0, tx_frame_sync_n: 1'b1,
                                   rx_frame_sync_n: 1'b1, data_pins: 12'h000};

endpackage : adc_if_pkg

// *** core/adc_host_interface.sv ***
// Host-facing digital interface of an eight-channel 12-bit converter.
// Assumes the host drives the serial clock, idling low between frames, and
// that the converter core hands a straight-binary code on i_adc_code.
`timescale 1ns/1ps

// Overview of operation
// - Chip select gates write and read strobes
// - Drive data pins only while read and select low
// - Write strobe with select captures control word
// - Write rising edge starts settling delay pulse
// - Soft convert set: delay expiry starts conversion
// - Soft convert clear: write leaves conversion untouched
// - Mode high selects twelve-pin parallel port
// - Result bit 0 to bit 11 on pins
// - Coding bit selects two's complement or binary
// - Parallel write latches address and control pins
// - Mode low gives five pins serial roles
// - Sixteen out bits: coding, address, result
// - Output bit valid at each falling clock edge
// - First six serial input bits load control
// - Later serial input bits are ignored
// - Convert start rising edge starts conversion
// - Conversion end gives short low done pulse
// - Control word clears to zero at reset
// - Short serial frame keeps word, may reconvert
module adc_host_interface (
    input wire logic i_ref_clk,                          // Reference clock
    input wire logic i_resetn,                           // Reset, active low; synchronous except for the serial word toggle
    input wire logic i_sclk,                             // Host serial clock
    input wire logic i_mode,                             // Port select pin
    input wire logic i_cs_n,                             // Chip select
    input wire logic i_rd_n,                             // Read strobe
    input wire logic i_wr_n,                             // Write strobe
    input wire logic i_convert_start_in,                 // Hardware convert start
    input wire logic [adc_if_pkg::DATA_W-1:0] i_data_pins, // Data pins, input side
    input wire logic i_tx_frame_sync_n,                  // Serial transmit frame sync
    input wire logic i_rx_frame_sync_n,                  // Serial receive frame sync
    input wire logic i_serial_in,                        // Serial data input
    input wire logic [adc_if_pkg::DATA_W-1:0] i_adc_code, // Converter core code
    output logic [adc_if_pkg::DATA_W-1:0] o_data_pins,   // Data pins, output side
    output logic o_data_oe,                              // Data pin drive enable
    output logic o_serial_out,                           // Serial data output
    output logic o_serial_oe,                            // Serial output drive enable
    output logic o_eoc_n,                                // Conversion done pulse
    output logic o_hold,                                 // Track/hold in hold
    output logic o_sample,                               // Core samples its code now
    output logic [2:0] o_chan_addr,                      // Multiplexer address
    output logic o_standby                               // Standby request
);
    import adc_if_pkg::*;

    // Conversion sequence states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_DONE
    } conv_state_t;

    // Apply the selected output coding to a straight-binary code
    function automatic logic [DATA_W-1:0] code_result(input logic [DATA_W-1:0] raw,
                                                      input logic twos);
        code_result = twos ? {~raw[DATA_W-1], raw[DATA_W-2:0]} : raw;
    endfunction : code_result

    // ---------------- Reference clock domain ----------------

    pins_t pin_meta;                   // First synchroniser stage
    pins_t pin_sync;                   // Second synchroniser stage
    pins_t pin_prev;                   // Previous synchronised value, for edges
    ctrl_t ctrl;                       // Control word
    ctrl_t wr_capture;                 // Control bits captured while the write is low
    logic [DATA_W-1:0] result;         // Latest completed straight-binary code
    logic [DATA_W-1:0] ser_word_lo;    // Result bits offered to the serial side
    logic [3:0] ser_word_hi;           // Coding and address bits offered to the serial side
    conv_state_t state;                // Conversion sequence
    logic [CNT_W-1:0] conv_cnt;        // Cycles left in the current state
    logic [CNT_W-1:0] acq_cnt;         // Cycles left in the settling delay
    logic acq_run;                     // Settling delay pulse active
    logic word_tgl_meta;               // Serial word event, first stage
    logic word_tgl_sync;               // Serial word event, second stage
    logic word_tgl_prev;               // Serial word event, edge detect
    logic frame_got_word;              // A full word arrived in this transmit frame
    logic wr_rise;                     // Write strobe ended this cycle
    logic tfs_rise;                    // Transmit frame ended this cycle
    logic tfs_fall;                    // Transmit frame began this cycle
    logic ser_word_new;                // Serial word completed this cycle
    logic convert_start_in_rise;                 // Hardware convert start edge
    logic acq_expire;                  // Settling delay runs out this cycle
    logic start_conv;                  // Begin a conversion this cycle

    // Serial link domain signals, declared here for the crossings
    ctrl_t ser_shift;                  // Serial input shift register
    logic [4:0] ser_in_cnt;            // Serial input bits taken in this frame
    logic word_tgl;                    // Toggles once per full serial word
    logic [4:0] ser_out_cnt;           // Serial output bits sent in this frame
    logic [SER_FRAME_BITS-1:0] ser_word; // Frozen word as one vector, first bit on top

    // Parallel port pins and frame strobes pass two flip-flops first
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pin_meta <= PINS_IDLE;
            pin_sync <= PINS_IDLE;
            pin_prev <= PINS_IDLE;
        end else begin
            pin_meta <= '{mode: i_mode, cs_n: i_cs_n, rd_n: i_rd_n, wr_n: i_wr_n,
                          convert_start_in: i_convert_start_in,
                          tx_frame_sync_n: i_tx_frame_sync_n,
                          rx_frame_sync_n: i_rx_frame_sync_n, data_pins: i_data_pins};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Serial word event crossing, toggle through two flip-flops
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            word_tgl_meta <= 1'b0;
            word_tgl_sync <= 1'b0;
            word_tgl_prev <= 1'b0;
        end else begin
            word_tgl_meta <= word_tgl;
            word_tgl_sync <= word_tgl_meta;
            word_tgl_prev <= word_tgl_sync;
        end
    end

    // Edge and event decode
    always_comb begin
        wr_rise = pin_sync.mode && pin_sync.wr_n && !pin_prev.wr_n && !pin_prev.cs_n;
        tfs_rise = !pin_sync.mode && pin_sync.tx_frame_sync_n && !pin_prev.tx_frame_sync_n;
        tfs_fall = !pin_sync.tx_frame_sync_n && pin_prev.tx_frame_sync_n;
        ser_word_new = !pin_sync.mode && (word_tgl_sync != word_tgl_prev);
        convert_start_in_rise = pin_sync.convert_start_in && !pin_prev.convert_start_in;
        acq_expire = acq_run && (acq_cnt == '0);
        start_conv = (state == ST_IDLE) &&
                     (convert_start_in_rise ||
                      (acq_expire && ctrl.soft_convert_bit) ||
                      (tfs_rise && !frame_got_word && ctrl.soft_convert_bit));
    end

    // Control bits follow the pins while select and write are both low
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            wr_capture <= CTRL_RESET;
        end else if (pin_sync.mode && !pin_sync.cs_n && !pin_sync.wr_n) begin
            wr_capture <= ctrl_t'(pin_sync.data_pins[CTRL_W-1:0]);
        end
    end

    // Control word: parallel write at strobe end, serial word when complete
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_rise) begin
            ctrl <= wr_capture;
        end else if (ser_word_new) begin
            ctrl <= ser_shift;
        end
    end

    // Track whether the current transmit frame delivered a full word
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            frame_got_word <= 1'b0;
        end else if (ser_word_new) begin
            frame_got_word <= 1'b1;                                   // Set wins over clear
        end else if (tfs_fall || tfs_rise) begin
            frame_got_word <= 1'b0;
        end
    end

    // Settling delay pulse, restarted by every control write
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            acq_run <= 1'b0;
            acq_cnt <= '0;
        end else if (wr_rise || ser_word_new) begin
            acq_run <= 1'b1;
            acq_cnt <= CNT_W'(ACQ_DELAY_CYC - 1);
        end else if (acq_run) begin
            acq_run <= (acq_cnt != '0);
            acq_cnt <= acq_cnt - 1'b1;
        end
    end

    // Conversion sequence: hold, convert, done pulse
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
            conv_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_conv) begin
                        state <= ST_CONVERT;
                        conv_cnt <= CNT_W'(CONV_TIME_CYC - 1);
                    end
                end
                ST_CONVERT: begin
                    if (conv_cnt == '0) begin
                        state <= ST_DONE;
                        conv_cnt <= CNT_W'(EOC_PULSE_CYC - 1);
                    end else begin
                        conv_cnt <= conv_cnt - 1'b1;
                    end
                end
                ST_DONE: begin
                    if (conv_cnt == '0) begin
                        state <= ST_IDLE;
                    end else begin
                        conv_cnt <= conv_cnt - 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Result register takes the core code at the end of each conversion
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            result <= '0;
        end else if (state == ST_CONVERT && conv_cnt == '0) begin
            result <= i_adc_code;
        end
    end

    // Converter-facing outputs, all registered
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_hold <= 1'b0;
            o_sample <= 1'b0;
            o_eoc_n <= 1'b1;
            o_chan_addr <= 3'h0;
            o_standby <= 1'b0;
        end else begin
            o_hold <= start_conv || (state == ST_CONVERT && conv_cnt != '0);
            o_sample <= (state == ST_CONVERT) && (conv_cnt == '0);
            o_eoc_n <= !((state == ST_CONVERT && conv_cnt == '0) ||
                         (state == ST_DONE && conv_cnt != '0));
            o_chan_addr <= ctrl.chan_addr;
            o_standby <= ctrl.soft_standby_bit;
        end
    end

    // Parallel read drivers, only while select and read are low
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_data_oe <= 1'b0;
            o_data_pins <= '0;
        end else begin
            o_data_oe <= pin_sync.mode && !pin_sync.cs_n && !pin_sync.rd_n;
            o_data_pins <= code_result(result, ctrl.coding_sel);
        end
    end

    // Word offered to the serial side, frozen while a receive frame runs
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            ser_word_hi <= 4'h0;
            ser_word_lo <= '0;
        end else if (pin_sync.rx_frame_sync_n) begin
            ser_word_hi <= {ctrl.coding_sel, ctrl.chan_addr};
            ser_word_lo <= code_result(result, ctrl.coding_sel);
        end
    end

    // ---------------- Serial link domain ----------------

    // Input bit count on falling serial clock; the frame's own sync clears it
    always_ff @(negedge i_sclk or posedge i_tx_frame_sync_n) begin
        if (i_tx_frame_sync_n) begin
            ser_in_cnt <= 5'h00;
        end else if (ser_in_cnt < SER_IN_BITS) begin
            ser_in_cnt <= ser_in_cnt + 5'h01;
        end
    end

    // Shift register takes only the first six bits of a frame
    always_ff @(negedge i_sclk) begin
        if (!i_tx_frame_sync_n && ser_in_cnt < SER_IN_BITS) begin
            ser_shift <= {ser_shift[CTRL_W-2:0], i_serial_in};
        end
    end

    // Word event: toggles when the sixth bit is taken
    always_ff @(negedge i_sclk or negedge i_resetn) begin
        if (!i_resetn) begin
            word_tgl <= 1'b0;
        end else if (!i_tx_frame_sync_n && ser_in_cnt == SER_IN_BITS - 5'h01) begin
            word_tgl <= ~word_tgl;
        end
    end

    // Output bit count, cleared while the receive sync is high
    always_ff @(posedge i_sclk or posedge i_rx_frame_sync_n) begin
        if (i_rx_frame_sync_n) begin
            ser_out_cnt <= 5'h00;
        end else if (ser_out_cnt < SER_OUT_BITS) begin
            ser_out_cnt <= ser_out_cnt + 5'h01;
        end
    end

    // Frozen word joined once, so the output stage can pick one bit from it
    assign ser_word = {ser_word_hi, ser_word_lo};

    // Output bit changes on rising edge, valid at the next falling edge
    always_ff @(posedge i_sclk or posedge i_rx_frame_sync_n) begin
        if (i_rx_frame_sync_n) begin
            o_serial_out <= 1'b0;
            o_serial_oe <= 1'b0;
        end else if (ser_out_cnt < SER_OUT_BITS) begin
            o_serial_out <= ser_word[4'hf - ser_out_cnt[3:0]];
            o_serial_oe <= 1'b1;
        end else begin
            o_serial_oe <= 1'b0;
        end
    end

endmodule : adc_host_interface

// *** tb/adc_host_interface_monitor.sv ***
// Concurrent checks on the converter host interface pins.
// Assumes the host serial clock idles low and both frame syncs are tied.
`timescale 1ns/1ps
module adc_host_interface_monitor (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_sclk,
    input wire logic i_mode,
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic i_tx_frame_sync_n,
    input wire logic i_rx_frame_sync_n,
    input wire logic o_data_oe,
    input wire logic o_serial_oe,
    input wire logic o_eoc_n,
    input wire logic o_hold,
    input wire logic o_sample,
    input wire logic [2:0] o_chan_addr,
    input wire logic o_standby
);
    logic rd_req; // Parallel read asked at the pins
    logic [4:0] quiet_cnt; // Cycles without write activity
    logic [4:0] oe_cnt; // Serial bits driven in this frame
    assign rd_req = !i_cs_n && !i_rd_n && i_mode;
    // Idle cycles since the last write strobe or frame
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || !i_wr_n || !i_tx_frame_sync_n || !i_rx_frame_sync_n) begin
            quiet_cnt <= 5'h00;
        end else if (quiet_cnt != 5'h1f) begin
            quiet_cnt <= quiet_cnt + 5'h01;
        end
    end
    // Driven serial bits, cleared while the frame is closed
    always_ff @(posedge i_sclk or posedge i_rx_frame_sync_n) begin
        if (i_rx_frame_sync_n) begin
            oe_cnt <= 5'h00;
        end else if (o_serial_oe) begin
            oe_cnt <= oe_cnt + 5'h01;
        end
    end
    // Done pulse: eight low cycles, then high again
    sequence eoc_pulse_s;
        (!o_eoc_n) [*8] ##1 o_eoc_n;
    endsequence
    // Drivers come up three cycles after the strobes
    sequence read_open_s;
        ##3 o_data_oe;
    endsequence
    chk_read_gate: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_data_oe |-> $past(rd_req, 3)) else $error("data pins driven without a read");
    chk_read_open: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(rd_req) |-> read_open_s) else $error("read did not enable the drivers");
    chk_eoc_width: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $fell(o_eoc_n) |-> eoc_pulse_s) else $error("done pulse has wrong length");
    chk_conv_length: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(o_hold) |-> ##[140:160] !o_eoc_n) else $error("conversion did not end in time");
    chk_sample_done: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_sample |-> ##[0:2] !o_eoc_n) else $error("sample without done pulse");
    chk_reset_state: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        $rose(i_resetn) |-> o_chan_addr == 3'h0 && !o_standby && o_eoc_n && !o_hold)
        else $error("outputs not cleared by reset");
    chk_word_holds: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        quiet_cnt > 5'h0a |-> $stable(o_chan_addr) && $stable(o_standby))
        else $error("control word changed with no write");
    chk_serial_len: assert property (@(posedge i_sclk) disable iff (!i_resetn)
        oe_cnt <= 5'h10) else $error("more than sixteen serial bits");
    chk_serial_frame: assert property (@(posedge i_sclk) disable iff (!i_resetn)
        o_serial_oe |-> !i_rx_frame_sync_n) else $error("serial output outside frame");
endmodule : adc_host_interface_monitor

bind adc_host_interface adc_host_interface_monitor mon (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_sclk(i_sclk), .i_mode(i_mode),
    .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
    .i_tx_frame_sync_n(i_tx_frame_sync_n), .i_rx_frame_sync_n(i_rx_frame_sync_n),
    .o_data_oe(o_data_oe), .o_serial_oe(o_serial_oe), .o_eoc_n(o_eoc_n),
    .o_hold(o_hold), .o_sample(o_sample), .o_chan_addr(o_chan_addr), .o_standby(o_standby)
);

// *** tb/serial_host_model.sv ***
// Host side of the serial port: clock, tied frame syncs and data in.
// Assumes the caller leaves time between frames for the word to settle.
`timescale 1ns/1ps
module serial_host_model (
    output logic o_sclk, // Host serial clock, low between frames
    output logic o_frame_n, // Both frame syncs, tied together
    output logic o_sdi, // Serial data into the device
    input wire logic i_sdo, // Serial data from the device
    input wire logic i_sdo_oe // Device drives serial data
);
    // Syncs start low and rise once, so the frame-cleared counters start known
    initial begin
        o_sclk = 1'b0;
        o_frame_n = 1'b0;
        o_sdi = 1'b0;
        #2;
        o_frame_n = 1'b1;
    end
    // One frame of nbits clocks, 32 ns period; bits past six toggle
    task automatic frame(input logic [5:0] word, input int nbits,
                         output logic [15:0] rx, output int nvalid);
        int i;
        rx = 16'h0000;
        nvalid = 0;
        #3.7;
        o_frame_n = 1'b0;
        #20;
        for (i = 0; i < nbits; i++) begin
            o_sclk = 1'b1;
            o_sdi = (i < 6) ? word[5 - i] : ~o_sdi;
            #16;
            rx = {rx[14:0], i_sdo};
            nvalid += (i_sdo_oe === 1'b1) ? 1 : 0;
            o_sclk = 1'b0;
            #16;
        end
        #20;
        o_frame_n = 1'b1;
        o_sdi = ~o_sdi; // Released line shows no stale bit
        #40;
    endtask : frame
endmodule : serial_host_model

// *** tb/test_adc_host_interface.sv ***
// Self-checking bench for the converter host interface.
// Assumes the serial host model and the bound pin checker beside it.
`timescale 1ns/1ps
module test_adc_host_interface;
    import adc_if_pkg::*;
    logic i_ref_clk = 1'b0, i_resetn = 1'b1, i_mode = 1'b1, i_cs_n = 1'b1;
    logic i_rd_n = 1'b1, i_wr_n = 1'b1, i_convert_start_in = 1'b0;
    logic [DATA_W-1:0] host_data = 12'h000, i_adc_code = 12'h3a5, i_data_pins, code;
    logic [DATA_W-1:0] o_data_pins;
    logic o_data_oe, o_serial_out, o_serial_oe, o_eoc_n, o_hold, o_sample, o_standby;
    logic [2:0] o_chan_addr;
    wire sclk, frame_n, sdi;
    logic hold_q = 1'b0;
    logic [15:0] rxw;
    int error_cnt = 0, n_checks = 0, hold_cnt = 0, nv;
    ctrl_t cw;
    // Shared pins: the device wins while it drives
    assign i_data_pins = o_data_oe ? o_data_pins : host_data;
    always #5 i_ref_clk = ~i_ref_clk;
    // Count conversions by the rise of hold
    always @(posedge i_ref_clk) begin
        hold_q <= o_hold;
        if (o_hold === 1'b1 && hold_q !== 1'b1) begin
            hold_cnt <= hold_cnt + 1;
        end
    end
    adc_host_interface dut (
        .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_sclk(sclk), .i_mode(i_mode),
        .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
        .i_convert_start_in(i_convert_start_in), .i_data_pins(i_data_pins),
        .i_tx_frame_sync_n(frame_n), .i_rx_frame_sync_n(frame_n), .i_serial_in(sdi),
        .i_adc_code(i_adc_code), .o_data_pins(o_data_pins), .o_data_oe(o_data_oe),
        .o_serial_out(o_serial_out), .o_serial_oe(o_serial_oe), .o_eoc_n(o_eoc_n),
        .o_hold(o_hold), .o_sample(o_sample), .o_chan_addr(o_chan_addr),
        .o_standby(o_standby)
    );
    serial_host_model host (.o_sclk(sclk), .o_frame_n(frame_n), .o_sdi(sdi),
        .i_sdo(o_serial_out), .i_sdo_oe(o_serial_oe));
    // Compare one value and count it
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task timeout;
        error_cnt++;
        $display("Error at %0t: wait bound used up", $time);
        report_and_stop;
    endtask : timeout
    task step(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : step
    // Parallel write: wr_n rises first, select a cycle later
    task wr(input ctrl_t w);
        i_cs_n = 1'b0;
        i_wr_n = 1'b0;
        host_data = {6'h00, w};
        step(5);
        i_wr_n = 1'b1;
        step(1);
        i_cs_n = 1'b1;
        step(6);
    endtask : wr
    // Parallel read: hold strobes until the drivers come up
    task rd(output logic [11:0] d);
        int i;
        i_cs_n = 1'b0;
        i_rd_n = 1'b0;
        for (i = 0; i < 20 && o_data_oe !== 1'b1; i++) step(1);
        if (i == 20) timeout;
        d = o_data_pins;
        i_rd_n = 1'b1;
        i_cs_n = 1'b1;
        step(6);
    endtask : rd
    task wait_eoc;
        int i;
        for (i = 0; i < 400 && o_eoc_n !== 1'b0; i++) step(1);
        if (i == 400) timeout;
        step(12);
    endtask : wait_eoc
    initial begin
        #1;
        i_resetn = 1'b0; // A real falling edge clears the serial-side word toggle
        step(10);
        i_resetn = 1'b1;
        step(4);
        check({9'h000, o_chan_addr, o_standby, o_eoc_n, o_hold, o_data_oe}, 16'h0004);
        $display("test reset done");
        cw = '{chan_addr: 3'h5, soft_convert_bit: 1'b0, soft_standby_bit: 1'b1, coding_sel: 1'b1};
        wr(cw);
        step(200);
        check({12'h000, o_chan_addr, o_standby}, {12'h000, cw.chan_addr, 1'b1});
        check(hold_cnt[15:0], 16'h0000);
        i_wr_n = 1'b0;
        host_data = 12'h03f;
        step(5);
        i_wr_n = 1'b1;
        i_rd_n = 1'b0;
        step(12);
        check({12'h000, o_chan_addr, o_data_oe}, {12'h000, cw.chan_addr, 1'b0});
        i_rd_n = 1'b1;
        $display("test parallel write done");
        i_convert_start_in = 1'b1;
        step(4);
        i_convert_start_in = 1'b0;
        wait_eoc;
        check(hold_cnt[15:0], 16'h0001);
        rd(code);
        check({4'h0, code}, 16'h0ba5);
        cw.coding_sel = 1'b0;
        wr(cw);
        rd(code);
        check({4'h0, code}, 16'h03a5);
        $display("test hardware convert done");
        i_adc_code = 12'h5c3;
        cw = '{chan_addr: 3'h2, soft_convert_bit: 1'b1, soft_standby_bit: 1'b0, coding_sel: 1'b0};
        wr(cw);
        step(20);
        check(hold_cnt[15:0], 16'h0001);
        wait_eoc;
        check(hold_cnt[15:0], 16'h0002);
        rd(code);
        check({4'h0, code}, 16'h05c3);
        $display("test soft convert done");
        i_mode = 1'b0;
        host_data = 12'h000;
        step(4);
        host.frame(6'b110001, 16, rxw, nv);
        check(rxw, 16'h25c3);
        check(nv[15:0], 16'h0010);
        step(12);
        check({12'h000, o_chan_addr, o_standby}, 16'h000c);
        host.frame(6'b110001, 16, rxw, nv);
        check(rxw, 16'hedc3);
        step(12);
        host.frame(6'b001110, 3, rxw, nv);
        step(250);
        check({12'h000, o_chan_addr, o_standby}, 16'h000c);
        check(hold_cnt[15:0], 16'h0002);
        host.frame(6'b110101, 18, rxw, nv);
        check(nv[15:0], 16'h0010);
        wait_eoc;
        check(hold_cnt[15:0], 16'h0003);
        host.frame(6'b000000, 4, rxw, nv);
        wait_eoc;
        check(hold_cnt[15:0], 16'h0004);
        check({13'h0000, o_chan_addr}, 16'h0006);
        $display("test serial port done");
        report_and_stop;
    end
endmodule : test_adc_host_interface
